// ==== src/bank_addr_pkg.sv ====
package bank_addr_pkg;

    // Address geometry
    localparam int          ADDR_W          = 12;
    localparam int          OFFS_W          = 8;
    localparam int          BANK_W          = 4;
    localparam int          DATA_W          = 8;
    localparam int          BANK_COUNT      = 16;

    // Access window split: offsets below this go to bank 0, the rest to bank 15
    localparam logic [7:0]  WINDOW_SPLIT    = 8'h60;
    localparam logic [3:0]  WINDOW_LOW_BANK = 4'h0;
    localparam logic [3:0]  WINDOW_HI_BANK  = 4'hf;

    // Bank pointer layout and reset value
    localparam logic [7:0]  BANK_PTR_RESET  = 8'h00;
    localparam logic [3:0]  BANK_PTR_UPPER  = 4'h0;

    // Default implemented-bank map: banks 0..5 and 15
    localparam logic [15:0] BANK_IMPL_DEFAULT = 16'h803f;

    // Access kinds presented by the decoder
    typedef enum logic [1:0]
    {
        ACC_NONE   = 2'b00,
        ACC_FILE   = 2'b01,
        ACC_MOVE   = 2'b11
    } acc_kind_t;

endpackage : bank_addr_pkg

// ==== src/bank_addr_if.sv ====
`timescale 1ns/100ps
// Request from the address former to the memory gate
interface bank_addr_if;
    import bank_addr_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
    modport src  (output addr, output rd, output wr, output wdata);
    modport sink (input addr, input rd, input wr, input wdata);
endinterface : bank_addr_if

// ==== src/bank_mem_gate.sv ====
`timescale 1ns/100ps
// Gates RAM strobes and read data on whether the target bank exists
module bank_mem_gate
    import bank_addr_pkg::*;
#(
    parameter logic [BANK_COUNT-1:0] BANK_IMPL = BANK_IMPL_DEFAULT
)
(
    bank_addr_if.sink           req,           // Formed access
    input  wire logic [DATA_W-1:0] i_ram_rdata, // Raw RAM data
    output logic                o_ram_wr,      // Gated write strobe
    output logic                o_ram_rd,      // Gated read strobe
    output logic [DATA_W-1:0]   o_rdata,       // Read value seen by core
    output logic                o_impl         // Target bank exists
);
    logic [BANK_W-1:0] bank;

    // Missing banks read zero and swallow writes
    always_comb
    begin
        bank     = req.addr[ADDR_W-1 -: BANK_W];
        o_impl   = BANK_IMPL[bank];
        o_ram_wr = req.wr & o_impl;
        o_ram_rd = req.rd & o_impl;
        o_rdata  = o_impl ? i_ram_rdata : {DATA_W{1'b0}};
    end
endmodule : bank_mem_gate

// ==== src/bank_addr_select.sv ====
`timescale 1ns/100ps
module bank_addr_select
    import bank_addr_pkg::*;
#(
    parameter logic [BANK_COUNT-1:0] BANK_IMPL = BANK_IMPL_DEFAULT
)
(
    input  wire logic                i_clk,         // Core clock
    input  wire logic                i_rst,         // Async reset, high
    input  wire logic                i_valid,       // Decoded access this cycle
    input  wire acc_kind_t           i_kind,        // File or move access
    input  wire logic                i_access_sel,  // Instruction a bit, 0 = window
    input  wire logic [OFFS_W-1:0]   i_file_offs,   // 8-bit file field
    input  wire logic [ADDR_W-1:0]   i_move_addr,   // Full address for moves
    input  wire logic                i_rd,          // Read requested
    input  wire logic                i_wr,          // Write requested
    input  wire logic [DATA_W-1:0]   i_wdata,       // Write data
    input  wire logic                i_lbl,         // Load-bank-literal instruction
    input  wire logic [DATA_W-1:0]   i_lbl_value,   // Its immediate
    input  wire logic                i_bp_wr,       // Register write to bank pointer
    input  wire logic [DATA_W-1:0]   i_bp_wdata,    // Its data
    input  wire logic [DATA_W-1:0]   i_ram_rdata,   // RAM read data
    output logic [ADDR_W-1:0]        o_ram_addr,    // RAM address
    output logic                     o_ram_rd,      // RAM read strobe
    output logic                     o_ram_wr,      // RAM write strobe
    output logic [DATA_W-1:0]        o_ram_wdata,   // RAM write data
    output logic [DATA_W-1:0]        o_rdata,       // Read data to ALU
    output logic                     o_flag_upd,    // ALU flags may update
    output logic                     o_bank_miss,   // Last access hit missing bank
    output logic [DATA_W-1:0]        o_bank_ptr     // Bank pointer readback
);
    logic [BANK_W-1:0]  bank_ptr_reg;
    logic [BANK_W-1:0]  bank_ptr_next;
    logic [ADDR_W-1:0]  addr_reg;
    logic [ADDR_W-1:0]  addr_next;
    logic               rd_reg;
    logic               rd_next;
    logic               wr_reg;
    logic               wr_next;
    logic [DATA_W-1:0]  wdata_reg;
    logic [DATA_W-1:0]  wdata_next;
    logic [DATA_W-1:0]  rdata_reg;
    logic               flag_reg;
    logic               flag_next;
    logic               miss_reg;
    logic               miss_next;
    logic               ram_rd_reg;
    logic               ram_rd_next;
    logic               ram_wr_reg;
    logic               ram_wr_next;
    logic [DATA_W-1:0]  rdata_next;
    logic [DATA_W-1:0]  gate_rdata;
    logic               gate_impl;
    logic               gate_rd;
    logic               gate_wr;

    bank_addr_if req_if ();

    // Bank pointer: literal load wins over a register write in the same cycle
    always_comb
    begin
        bank_ptr_next = bank_ptr_reg;
        if (i_lbl)
        begin
            bank_ptr_next = i_lbl_value[BANK_W-1:0];
        end
        else if (i_bp_wr)
        begin
            bank_ptr_next = i_bp_wdata[BANK_W-1:0];
        end
    end

    // Address forming; only four bits are stored so the upper nibble cannot be set
    always_comb
    begin
        addr_next  = addr_reg;
        rd_next    = 1'b0;
        wr_next    = 1'b0;
        wdata_next = wdata_reg;
        flag_next  = 1'b0;
        if (i_valid && i_kind != ACC_NONE)
        begin
            rd_next    = i_rd;
            wr_next    = i_wr;
            wdata_next = i_wdata;
            flag_next  = 1'b1;
            if (i_kind == ACC_MOVE)
            begin
                addr_next = i_move_addr;
            end
            else if (!i_access_sel)
            begin
                // Window: low 96 from bank 0, then bank 15 special registers
                if (i_file_offs < WINDOW_SPLIT)
                begin
                    addr_next = {WINDOW_LOW_BANK, i_file_offs};
                end
                else
                begin
                    addr_next = {WINDOW_HI_BANK, i_file_offs};
                end
            end
            else
            begin
                addr_next = {bank_ptr_reg, i_file_offs};
            end
        end
    end

    // Request state registers
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            bank_ptr_reg <= BANK_PTR_RESET[BANK_W-1:0];
            addr_reg     <= '0;
            rd_reg       <= 1'b0;
            wr_reg       <= 1'b0;
            wdata_reg    <= '0;
            flag_reg     <= 1'b0;
        end
        else
        begin
            bank_ptr_reg <= bank_ptr_next;
            addr_reg     <= addr_next;
            rd_reg       <= rd_next;
            wr_reg       <= wr_next;
            wdata_reg    <= wdata_next;
            flag_reg     <= flag_next;
        end
    end

    assign req_if.addr  = addr_reg;
    assign req_if.rd    = rd_reg;
    assign req_if.wr    = wr_reg;
    assign req_if.wdata = wdata_reg;

    bank_mem_gate #(
        .BANK_IMPL (BANK_IMPL)
    ) u_gate (
        .req         (req_if.sink),
        .i_ram_rdata (i_ram_rdata),
        .o_ram_wr    (gate_wr),
        .o_ram_rd    (gate_rd),
        .o_rdata     (gate_rdata),
        .o_impl      (gate_impl)
    );

    // Output stage next values; a missing bank only counts for a real read or write
    always_comb
    begin
        ram_rd_next = gate_rd;
        ram_wr_next = gate_wr;
        rdata_next  = gate_rdata;
        miss_next   = (rd_reg | wr_reg) & ~gate_impl;
    end

    // Gated strobes and data registered so every output leaves a flip-flop
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ram_rd_reg <= 1'b0;
            ram_wr_reg <= 1'b0;
            rdata_reg  <= '0;
            miss_reg   <= 1'b0;
        end
        else
        begin
            ram_rd_reg <= ram_rd_next;
            ram_wr_reg <= ram_wr_next;
            rdata_reg  <= rdata_next;
            miss_reg   <= miss_next;
        end
    end

    // Address and data delayed one stage to line up with the gated strobes
    logic [ADDR_W-1:0] ram_addr_reg;
    logic [ADDR_W-1:0] ram_addr_next;
    logic [DATA_W-1:0] ram_wdata_reg;
    logic [DATA_W-1:0] ram_wdata_next;
    logic              flag_out_reg;
    logic              flag_out_next;

    // Plain copy, so a pointer change never bends an access already in flight
    always_comb
    begin
        ram_addr_next  = addr_reg;
        ram_wdata_next = wdata_reg;
        flag_out_next  = flag_reg;
    end

    // Delay stage registers
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ram_addr_reg  <= '0;
            ram_wdata_reg <= '0;
            flag_out_reg  <= 1'b0;
        end
        else
        begin
            ram_addr_reg  <= ram_addr_next;
            ram_wdata_reg <= ram_wdata_next;
            flag_out_reg  <= flag_out_next;
        end
    end

    assign o_ram_addr  = ram_addr_reg;
    assign o_ram_rd    = ram_rd_reg;
    assign o_ram_wr    = ram_wr_reg;
    assign o_ram_wdata = ram_wdata_reg;
    assign o_rdata     = rdata_reg;
    assign o_flag_upd  = flag_out_reg;
    assign o_bank_miss = miss_reg;
    assign o_bank_ptr  = {BANK_PTR_UPPER, bank_ptr_reg};
endmodule : bank_addr_select

// ==== tb/bank_ram_model.sv ====
`timescale 1ns/100ps
// Combinational data RAM, one byte per location of the 4096-byte space
module bank_ram_model
    import bank_addr_pkg::*;
(
    input  wire logic [ADDR_W-1:0] i_addr, // Formed address
    output logic      [DATA_W-1:0] o_data  // Read data
);
    // Bank nibble mixed in so a wrong bank shows as wrong data
    assign o_data = i_addr[7:0] ^ {i_addr[11:8], i_addr[11:8]} ^ 8'h5a;
endmodule : bank_ram_model

// ==== tb/bank_addr_select_sva.sv ====
`timescale 1ns/100ps
module bank_addr_select_sva
    import bank_addr_pkg::*;
#(
    parameter logic [BANK_COUNT-1:0] BANK_IMPL = BANK_IMPL_DEFAULT
)
(
    input wire logic i_clk, i_rst, i_valid, i_access_sel, i_lbl, i_bp_wr, o_ram_rd, o_ram_wr, o_flag_upd, o_bank_miss,
    input wire acc_kind_t i_kind,
    input wire logic [7:0] i_file_offs, i_lbl_value, i_bp_wdata, o_rdata, o_bank_ptr,
    input wire logic [11:0] i_move_addr, o_ram_addr
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // An access is taken at the edge where it is presented
    sequence taken_s;
        i_valid && i_kind != ACC_NONE;
    endsequence
    sequence answer_s;
        ##2 o_flag_upd;
    endsequence
    bp_upper_a: assert property (o_bank_ptr[7:4] == 4'h0)
        else $error("bank pointer upper bits set");
    ptr_load_a: assert property (i_lbl |=> o_bank_ptr == {4'h0, 4'($past(i_lbl_value))})
        else $error("load literal not taken");
    ptr_write_a: assert property (i_bp_wr && !i_lbl |=> o_bank_ptr == {4'h0, 4'($past(i_bp_wdata))})
        else $error("pointer write wrong");
    flag_once_a: assert property (taken_s |-> answer_s)
        else $error("no flag update");
    flag_cause_a: assert property (o_flag_upd |-> $past(i_valid, 2) && $past(i_kind, 2) != ACC_NONE)
        else $error("flag without access");
    miss_gate_a: assert property (o_bank_miss |-> !o_ram_rd && !o_ram_wr && o_rdata == 8'h00)
        else $error("missing bank not gated");
    miss_map_a: assert property (o_flag_upd |-> o_bank_miss == !BANK_IMPL[o_ram_addr[11:8]])
        else $error("miss flag wrong");
    move_addr_a: assert property (taken_s ##0 i_kind == ACC_MOVE |-> ##2 o_ram_addr == $past(i_move_addr, 2))
        else $error("move address wrong");
    window_addr_a: assert property (taken_s ##0 i_kind == ACC_FILE && !i_access_sel |-> ##2
        o_ram_addr == {($past(i_file_offs, 2) < 8'h60 ? 4'h0 : 4'hf), $past(i_file_offs, 2)})
        else $error("window address wrong");
    banked_addr_a: assert property (taken_s ##0 i_kind == ACC_FILE && i_access_sel |-> ##2
        o_ram_addr == {4'($past(o_bank_ptr, 2)), $past(i_file_offs, 2)})
        else $error("banked address wrong");
endmodule : bank_addr_select_sva

// ==== tb/bank_addr_select_tb.sv ====
`timescale 1ns/100ps
module bank_addr_select_tb;
    import bank_addr_pkg::*;
    typedef struct {logic [11:0] a; logic q, rd, wr, miss; logic [7:0] wd, rdv;} note_t;
    logic i_clk = 0, i_rst = 1, i_valid = 0, i_access_sel = 0, i_rd = 0, i_wr = 0, i_lbl = 0, i_bp_wr = 0;
    logic o_ram_rd, o_ram_wr, o_flag_upd, o_bank_miss;
    acc_kind_t i_kind = ACC_NONE;
    logic [7:0] i_file_offs = '0, i_wdata = '0, i_lbl_value = '0, i_bp_wdata = '0;
    logic [7:0] i_ram_rdata, o_ram_wdata, o_rdata, o_bank_ptr;
    logic [11:0] i_move_addr = '0, o_ram_addr, addr_q = '0, addr_d1;
    logic [3:0] bp = 4'h0;
    int fails = 0, n_tests = 0;
    note_t notes[$], mn;
    logic [7:0] wo[4] = '{8'h00, 8'h5f, 8'h60, 8'hff};
    acc_kind_t kinds[3] = '{ACC_NONE, ACC_FILE, ACC_MOVE};
    always #25 i_clk = ~i_clk;
    bank_addr_select i_bank_addr_select (.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid), .i_kind(i_kind),
        .i_access_sel(i_access_sel), .i_file_offs(i_file_offs), .i_move_addr(i_move_addr), .i_rd(i_rd),
        .i_wr(i_wr), .i_wdata(i_wdata), .i_lbl(i_lbl), .i_lbl_value(i_lbl_value), .i_bp_wr(i_bp_wr),
        .i_bp_wdata(i_bp_wdata), .i_ram_rdata(i_ram_rdata), .o_ram_addr(o_ram_addr), .o_ram_rd(o_ram_rd),
        .o_ram_wr(o_ram_wr), .o_ram_wdata(o_ram_wdata), .o_rdata(o_rdata), .o_flag_upd(o_flag_upd),
        .o_bank_miss(o_bank_miss), .o_bank_ptr(o_bank_ptr));
    bank_ram_model i_bank_ram_model (.i_addr(addr_d1), .o_data(i_ram_rdata));
    // RAM sees the formed address from the taking edge on, like the internal address
    always @(posedge i_clk)
    begin
        addr_d1 <= addr_q;
    end
    task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Drive one access for one cycle and note what must come back
    task automatic acc(acc_kind_t k, logic s, logic [7:0] f, logic [11:0] m, logic r, logic w, logic [7:0] d);
        note_t n;
        n.a = k == ACC_MOVE ? m : s ? {bp, f} : f < 8'h60 ? {4'h0, f} : {4'hf, f};
        n.miss = !BANK_IMPL_DEFAULT[n.a[11:8]];
        {n.q, n.rd, n.wr, n.wd} = {r, r & !n.miss, w & !n.miss, d};
        n.rdv = n.rd ? n.a[7:0] ^ {n.a[11:8], n.a[11:8]} ^ 8'h5a : 8'h00;
        if (k != ACC_NONE)
            notes.push_back(n);
        {i_valid, i_access_sel, i_file_offs, i_move_addr, i_rd, i_wr, i_wdata} = {1'b1, s, f, m, r, w, d};
        i_kind = k;
        {i_lbl, i_bp_wr, addr_q} = {2'b00, n.a};
        @(posedge i_clk) #1;
    endtask : acc
    task automatic bpset(logic l, logic [7:0] lv, logic w, logic [7:0] wv);
        {i_valid, i_lbl, i_lbl_value, i_bp_wr, i_bp_wdata} = {1'b0, l, lv, w, wv};
        @(posedge i_clk) #1;
        bp = l ? lv[3:0] : w ? wv[3:0] : bp;
        check("bank_ptr", o_bank_ptr, {4'h0, bp});
    endtask : bpset
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // Each flag pulse closes the oldest access in flight
    always @(posedge i_clk)
    begin
        #2;
        if (o_flag_upd === 1'b1)
        begin
            mn = notes.pop_front();
            check("addr", o_ram_addr, mn.a);
            check("rd", o_ram_rd, mn.rd);
            check("wr", o_ram_wr, mn.wr);
            check("miss", o_bank_miss, mn.miss);
            if (mn.q)
                check("rdata", o_rdata, mn.rdv);
            if (mn.wr)
                check("wdata", o_ram_wdata, mn.wd);
        end
    end
    initial
    begin
        void'($urandom(22));
        repeat (2) @(posedge i_clk);
        #1 i_rst = 0;
        check("ptr_reset", o_bank_ptr, {4'h0, BANK_PTR_RESET[3:0]});
        // Both sides of the window split, back to back
        foreach (wo[j]) acc(ACC_FILE, 0, wo[j], 12'h000, 1, j[0], 8'h3c);
        $display("test window done");
        // Every bank, read then write; upper pointer bits must be dropped
        for (int b = 0; b < 16; b++)
        begin
            bpset(1, 8'hf0 | 8'(b), 0, 8'h00);
            acc(ACC_FILE, 1, 8'($urandom), 12'h000, 1, 0, 8'h00);
            acc(ACC_FILE, 1, 8'($urandom), 12'h000, 0, 1, 8'($urandom));
        end
        $display("test banks done");
        bpset(0, 8'h00, 1, 8'ha5);
        bpset(1, 8'h03, 1, 8'h0c);
        repeat (8) acc(ACC_MOVE, 1, 8'h00, 12'($urandom), 1, 1'($urandom), 8'($urandom));
        $display("test ptr and move done");
        // Random traffic with pointer changes in between
        repeat (60)
        begin
            if ($urandom % 4 == 0)
                bpset(1'($urandom), 8'($urandom), 1'($urandom), 8'($urandom));
            acc(kinds[$urandom % 3], 1'($urandom), 8'($urandom), 12'($urandom), 1, 1'($urandom), 8'($urandom));
        end
        bpset(0, 8'h00, 0, 8'h00);
        repeat (4) @(posedge i_clk);
        check("pending", 12'(notes.size()), 12'h000);
        $display("test random done");
        summarize();
    end
    initial
    begin
        #100us;
        fails++;
        summarize();
    end
endmodule : bank_addr_select_tb
bind bank_addr_select bank_addr_select_sva #(.BANK_IMPL(BANK_IMPL)) i_bank_addr_select_sva (.i_clk(i_clk),
    .i_rst(i_rst), .i_valid(i_valid), .i_access_sel(i_access_sel), .i_lbl(i_lbl), .i_bp_wr(i_bp_wr),
    .o_ram_rd(o_ram_rd), .o_ram_wr(o_ram_wr), .o_flag_upd(o_flag_upd), .o_bank_miss(o_bank_miss),
    .i_kind(i_kind), .i_file_offs(i_file_offs), .i_lbl_value(i_lbl_value), .i_bp_wdata(i_bp_wdata),
    .o_rdata(o_rdata), .o_bank_ptr(o_bank_ptr), .i_move_addr(i_move_addr), .o_ram_addr(o_ram_addr));
